/* src/nine_bit_uart.sv */
`default_nettype none
module nine_bit_uart (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [11:0] adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic        timer1_ovf_i,
   input  wire logic        rxd_i,
   output logic             rxd_o,
   output logic             rxd_oe_o,
   output logic             txd_o
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic             ack_r,  ack_nxt;
   logic [31:0]      dat_r,  dat_nxt;
   logic [7:0]       pwr_r,  pwr_nxt;
   logic [7:0]       serial_control_r, serial_control_nxt;
   logic [7:0]       rxb_r,  rxb_nxt;
   logic [7:0]       bfr_r,  bfr_nxt;
   logic [4:0]       bint_r, bint_nxt;
   logic [7:0]       t2c_r,  t2c_nxt;
   logic [15:0]      rl_r,   rl_nxt;
   logic             xen_r,  xen_nxt;
   logic             ovr_r,  ovr_nxt;
   logic [2:0]       sy_r;
   logic             rxs_r,  rxs_nxt;
   logic             rxp_r;
   logic [3:0]       m0c_r,  m0c_nxt;
   logic             half_r, half_nxt;
   logic             t1h_r,  t1h_nxt;
   logic [15:0]      t2_r,   t2_nxt;
   logic [16:0]      fr_r,   fr_nxt;
   logic [16:0]      fr_sum, fr_thr;
   logic [3:0]       fr_n;
   logic             m0_tk,  t2_ovf, ded_tk, t1_tk, m2_tk;
   logic             tx16,   rx16;
   u9_pkg::shift_st_e sh_st_r, sh_st_nxt;
   logic [10:0]      sh_d_r, sh_d_nxt;
   logic [3:0]       sh_c_r, sh_c_nxt;
   logic [3:0]       sh_o_r, sh_o_nxt;
   logic             txd_r,  txd_nxt;
   logic             rxo_r,  rxo_nxt;
   logic             rxe_r,  rxe_nxt;
   logic             btk,    tf_set, sh_ld;
   logic [7:0]       sh_ldd;
   u9_pkg::rx_st_e   rx_st_r, rx_st_nxt;
   logic [3:0]       rx_o_r, rx_o_nxt;
   logic [3:0]       rx_c_r, rx_c_nxt;
   logic [8:0]       rx_s_r, rx_s_nxt;
   logic             rx_ld,  rx_nin;
   logic [7:0]       rx_ldd;
   logic [7:0]       idx;
   logic             req,    wr,  rd, bufwr;
   logic             mode0,  nine, fixed9, ren, rf;
   logic             ded_en, dbl, t2tx, t2rx, t2_run;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] k);
      return a == k;
   endfunction

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   assign idx    = adr_i[9:2];
   assign req    = cyc_i & stb_i & ~ack_r & ~|adr_i[11:10];
   assign wr     = req & we_i & sel_i[0];
   assign rd     = req & ~we_i;
   assign bufwr  = wr & hit(idx, u9_pkg::IX_BUF);
   assign mode0  = ~serial_control_r[u9_pkg::B_M0] & ~serial_control_r[u9_pkg::B_M1];
   assign nine   = serial_control_r[u9_pkg::B_M0];
   assign fixed9 = serial_control_r[u9_pkg::B_M0] & ~serial_control_r[u9_pkg::B_M1];
   assign ren    = serial_control_r[u9_pkg::B_REN];
   assign rf     = serial_control_r[u9_pkg::B_RF];
   assign ded_en = bfr_r[u9_pkg::B_DEN];
   // Doubling and Timer 2 selects are ignored under the divider
   assign dbl    = pwr_r[u9_pkg::B_DBL] & ~ded_en;
   assign t2tx   = t2c_r[u9_pkg::B_T2TX] & ~ded_en;
   assign t2rx   = t2c_r[u9_pkg::B_T2RX] & ~ded_en;
   assign t2_run = t2tx | t2rx;

   // ----------------------------------------
   // Input synchroniser
   // ----------------------------------------
   always_comb begin
      rxs_nxt = rxs_r;
      if (sy_r[1] == sy_r[2]) begin
         rxs_nxt = sy_r[2];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sy_r  <= 3'h7;
         rxs_r <= 1'b1;
         rxp_r <= 1'b1;
      end else begin
         sy_r  <= {sy_r[1:0], rxd_i};
         rxs_r <= rxs_nxt;
         rxp_r <= rxs_r;
      end
   end

   // ----------------------------------------
   // Baud sources, all as 16x ticks except the mode 0 bit tick
   // ----------------------------------------
   always_comb begin
      m0_tk    = (m0c_r == u9_pkg::M0_LAST);
      m0c_nxt  = m0_tk ? '0 : m0c_r + 4'h1;
      half_nxt = ~half_r;
      t1h_nxt  = t1h_r ^ timer1_ovf_i;
      t1_tk    = timer1_ovf_i & (dbl | t1h_r);
      m2_tk    = dbl | half_r;
      t2_ovf   = 1'b0;
      t2_nxt   = t2_r;
      if (!t2_run) begin
         t2_nxt = rl_r;
      end else if (half_r) begin
         if (t2_r == u9_pkg::T2_TOP) begin
            t2_nxt = rl_r;
            t2_ovf = 1'b1;
         end else begin
            t2_nxt = t2_r + 16'h0001;
         end
      end
      // Fractional accumulator: tick rate clk*(64+f)/(64*2^n)
      fr_n   = {1'b0, bint_r[u9_pkg::DIV_LSB +: 3]}
             + {2'h0, bint_r[u9_pkg::EXT_LSB +: 2]};
      fr_sum = fr_r + u9_pkg::FR_BASE + {11'h000, bfr_r[5:0]};
      fr_thr = 17'h00001 << (u9_pkg::FR_SH + int'(fr_n));
      ded_tk = ded_en & (fr_sum >= fr_thr);
      if (!ded_en) begin
         fr_nxt = '0;
      end else if (ded_tk) begin
         fr_nxt = fr_sum - fr_thr;
      end else begin
         fr_nxt = fr_sum;
      end
      if (fixed9) begin
         tx16 = m2_tk;
         rx16 = m2_tk;
      end else if (ded_en) begin
         tx16 = ded_tk;
         rx16 = ded_tk;
      end else begin
         tx16 = t2tx ? t2_ovf : t1_tk;
         rx16 = t2rx ? t2_ovf : t1_tk;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         m0c_r  <= '0;
         half_r <= 1'b0;
         t1h_r  <= 1'b0;
         t2_r   <= u9_pkg::RST16;
         fr_r   <= '0;
      end else begin
         m0c_r  <= m0c_nxt;
         half_r <= half_nxt;
         t1h_r  <= t1h_nxt;
         t2_r   <= t2_nxt;
         fr_r   <= fr_nxt;
      end
   end

   // ----------------------------------------
   // Transmit and shift-mode engine
   // ----------------------------------------
   always_comb begin
      sh_st_nxt = sh_st_r;
      sh_d_nxt  = sh_d_r;
      sh_c_nxt  = sh_c_r;
      sh_o_nxt  = tx16 ? sh_o_r + 4'h1 : sh_o_r;
      tf_set    = 1'b0;
      sh_ld     = 1'b0;
      sh_ldd    = {rxs_r, sh_d_r[7:1]};
      btk       = mode0 ? m0_tk : (tx16 & (sh_o_r == u9_pkg::OVS_LAST));
      case (sh_st_r)
         u9_pkg::SH_IDLE: begin
            if (mode0 && ren && !rf) begin
               sh_st_nxt = u9_pkg::SH_SHIN;
               sh_c_nxt  = u9_pkg::LEN0;
            end
         end
         u9_pkg::SH_WAIT: begin
            if (btk) begin
               sh_st_nxt = u9_pkg::SH_SEND;
            end
         end
         u9_pkg::SH_SEND: begin
            if (btk) begin
               if (sh_c_r == 4'h1) begin
                  sh_st_nxt = u9_pkg::SH_IDLE;
                  tf_set    = mode0;
               end else begin
                  sh_d_nxt = {1'b1, sh_d_r[10:1]};
                  sh_c_nxt = sh_c_r - 4'h1;
                  tf_set   = ~mode0 & (sh_c_r == 4'h2);
               end
            end
         end
         u9_pkg::SH_SHIN: begin
            if (btk) begin
               sh_d_nxt = {sh_d_r[10:8], sh_ldd};
               sh_c_nxt = sh_c_r - 4'h1;
               if (sh_c_r == 4'h1) begin
                  sh_ld     = 1'b1;
                  sh_st_nxt = u9_pkg::SH_IDLE;
               end
            end
         end
         default: begin
            sh_st_nxt = u9_pkg::SH_IDLE;
         end
      endcase
      // A write restarts the engine even mid frame
      if (bufwr) begin
         sh_st_nxt = u9_pkg::SH_WAIT;
         sh_ld     = 1'b0;
         if (mode0) begin
            sh_d_nxt = {3'h7, dat_i[7:0]};
            sh_c_nxt = u9_pkg::LEN0;
         end else begin
            sh_d_nxt = {1'b1, nine ? serial_control_r[u9_pkg::B_TB8] : 1'b1,
                        dat_i[7:0], 1'b0};
            sh_c_nxt = nine ? u9_pkg::LEN9 : u9_pkg::LEN8;
         end
      end
      txd_nxt = 1'b1;
      rxo_nxt = 1'b1;
      rxe_nxt = 1'b0;
      if (mode0) begin
         if (sh_st_nxt == u9_pkg::SH_SEND || sh_st_nxt == u9_pkg::SH_SHIN) begin
            txd_nxt = (m0c_nxt >= u9_pkg::M0_HALF);
         end
         if (sh_st_nxt == u9_pkg::SH_SEND) begin
            rxo_nxt = sh_d_nxt[0];
            rxe_nxt = 1'b1;
         end
      end else if (sh_st_nxt == u9_pkg::SH_SEND) begin
         txd_nxt = sh_d_nxt[0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sh_st_r <= u9_pkg::SH_IDLE;
         sh_d_r  <= '1;
         sh_c_r  <= '0;
         sh_o_r  <= '0;
         txd_r   <= 1'b1;
         rxo_r   <= 1'b1;
         rxe_r   <= 1'b0;
      end else begin
         sh_st_r <= sh_st_nxt;
         sh_d_r  <= sh_d_nxt;
         sh_c_r  <= sh_c_nxt;
         sh_o_r  <= sh_o_nxt;
         txd_r   <= txd_nxt;
         rxo_r   <= rxo_nxt;
         rxe_r   <= rxe_nxt;
      end
   end

   // ----------------------------------------
   // Asynchronous receiver
   // ----------------------------------------
   always_comb begin
      rx_st_nxt = rx_st_r;
      rx_o_nxt  = rx16 ? rx_o_r + 4'h1 : rx_o_r;
      rx_c_nxt  = rx_c_r;
      rx_s_nxt  = rx_s_r;
      rx_ld     = 1'b0;
      rx_nin    = nine ? rx_s_r[8] : rxs_r;
      rx_ldd    = nine ? rx_s_r[7:0] : rx_s_r[8:1];
      case (rx_st_r)
         u9_pkg::RX_IDLE: begin
            rx_o_nxt = '0;
            if (!mode0 && ren && rxp_r && !rxs_r) begin
               rx_st_nxt = u9_pkg::RX_START;
            end
         end
         u9_pkg::RX_START: begin
            if (rx16 && rx_o_r == u9_pkg::OVS_MID) begin
               rx_o_nxt = '0;
               if (rxs_r) begin
                  rx_st_nxt = u9_pkg::RX_IDLE;
               end else begin
                  rx_st_nxt = u9_pkg::RX_DATA;
                  rx_c_nxt  = nine ? u9_pkg::DAT9 : u9_pkg::DAT8;
               end
            end
         end
         u9_pkg::RX_DATA: begin
            if (rx16 && rx_o_r == u9_pkg::OVS_LAST) begin
               rx_s_nxt = {rxs_r, rx_s_r[8:1]};
               rx_c_nxt = rx_c_r - 4'h1;
               if (rx_c_r == 4'h1) begin
                  rx_st_nxt = u9_pkg::RX_STOP;
               end
            end
         end
         u9_pkg::RX_STOP: begin
            // Final shift pulse: acceptance is decided here
            if (rx16 && rx_o_r == u9_pkg::OVS_LAST) begin
               rx_st_nxt = u9_pkg::RX_IDLE;
               rx_ld = (xen_r | ~rf)
                     & (~serial_control_r[u9_pkg::B_MP] | rx_nin);
            end
         end
         default: begin
            rx_st_nxt = u9_pkg::RX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_st_r <= u9_pkg::RX_IDLE;
         rx_o_r  <= '0;
         rx_c_r  <= '0;
         rx_s_r  <= '0;
      end else begin
         rx_st_r <= rx_st_nxt;
         rx_o_r  <= rx_o_nxt;
         rx_c_r  <= rx_c_nxt;
         rx_s_r  <= rx_s_nxt;
      end
   end

   // ----------------------------------------
   // Register file on the bus
   // ----------------------------------------
   always_comb begin
      // Out-of-range addresses are acked too, so the master never hangs
      ack_nxt  = cyc_i & stb_i & ~ack_r;
      dat_nxt  = '0;
      pwr_nxt  = pwr_r;
      serial_control_nxt = serial_control_r;
      rxb_nxt  = rxb_r;
      bfr_nxt  = bfr_r;
      bint_nxt = bint_r;
      t2c_nxt  = t2c_r;
      rl_nxt   = rl_r;
      xen_nxt  = xen_r;
      ovr_nxt  = ovr_r;
      if (rd) begin
         case (idx)
            u9_pkg::IX_PWR:  dat_nxt[7:0] = pwr_r;
            u9_pkg::IX_SCTL: dat_nxt[7:0] = serial_control_r;
            u9_pkg::IX_BUF:  dat_nxt[7:0] = rxb_r;
            u9_pkg::IX_BFR:  dat_nxt[7:0] = bfr_r;
            u9_pkg::IX_BINT: dat_nxt[4:0] = bint_r;
            u9_pkg::IX_UEXT: dat_nxt[1:0] = {ovr_r, xen_r};
            u9_pkg::IX_T2C:  dat_nxt[7:0] = t2c_r;
            u9_pkg::IX_RLL:  dat_nxt[7:0] = rl_r[7:0];
            u9_pkg::IX_RLH:  dat_nxt[7:0] = rl_r[15:8];
            default:         dat_nxt      = '0;
         endcase
         if (hit(idx, u9_pkg::IX_BUF)) begin
            ovr_nxt = 1'b0;
         end
      end
      if (wr) begin
         case (idx)
            u9_pkg::IX_PWR:  pwr_nxt  = dat_i[7:0];
            u9_pkg::IX_SCTL: serial_control_nxt = dat_i[7:0];
            u9_pkg::IX_BFR:  bfr_nxt  = dat_i[7:0] & 8'hBF;
            u9_pkg::IX_BINT: bint_nxt = dat_i[4:0];
            u9_pkg::IX_UEXT: xen_nxt  = dat_i[u9_pkg::B_XEN];
            u9_pkg::IX_T2C:  t2c_nxt  = dat_i[7:0];
            u9_pkg::IX_RLL:  rl_nxt[7:0]  = dat_i[7:0];
            u9_pkg::IX_RLH:  rl_nxt[15:8] = dat_i[7:0];
            default:         pwr_nxt  = pwr_r;
         endcase
      end
      // Hardware sets win over a software clear in the same cycle
      if (tf_set) begin
         serial_control_nxt[u9_pkg::B_TF] = 1'b1;
      end
      if (sh_ld) begin
         rxb_nxt                = sh_ldd;
         serial_control_nxt[u9_pkg::B_RF] = 1'b1;
      end
      if (rx_ld) begin
         rxb_nxt                 = rx_ldd;
         serial_control_nxt[u9_pkg::B_RB8] = rx_nin;
         serial_control_nxt[u9_pkg::B_RF]  = 1'b1;
         if (rf) begin
            ovr_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r  <= 1'b0;
         dat_r  <= '0;
         pwr_r  <= u9_pkg::RST8;
         serial_control_r <= u9_pkg::RST8;
         rxb_r  <= u9_pkg::RST8;
         bfr_r  <= u9_pkg::RST8;
         bint_r <= '0;
         t2c_r  <= u9_pkg::RST8;
         rl_r   <= u9_pkg::RST16;
         xen_r  <= 1'b0;
         ovr_r  <= 1'b0;
      end else begin
         ack_r  <= ack_nxt;
         dat_r  <= dat_nxt;
         pwr_r  <= pwr_nxt;
         serial_control_r <= serial_control_nxt;
         rxb_r  <= rxb_nxt;
         bfr_r  <= bfr_nxt;
         bint_r <= bint_nxt;
         t2c_r  <= t2c_nxt;
         rl_r   <= rl_nxt;
         xen_r  <= xen_nxt;
         ovr_r  <= ovr_nxt;
      end
   end

   assign dat_o    = dat_r;
   assign ack_o    = ack_r;
   assign txd_o    = txd_r;
   assign rxd_o    = rxo_r;
   assign rxd_oe_o = rxe_r;
endmodule
`default_nettype wire

/* src/u9_pkg.sv */
`default_nettype none
package u9_pkg;
   // ----------------------------------------
   // Register indices, byte address is 4 x index
   // ----------------------------------------
   localparam logic [7:0] IX_PWR  = 8'h87;
   localparam logic [7:0] IX_SCTL = 8'h98;
   localparam logic [7:0] IX_BUF  = 8'h99;
   localparam logic [7:0] IX_BFR  = 8'h9D;
   localparam logic [7:0] IX_BINT = 8'h9E;
   localparam logic [7:0] IX_UEXT = 8'hA0;
   localparam logic [7:0] IX_T2C  = 8'hC8;
   localparam logic [7:0] IX_RLL  = 8'hCA;
   localparam logic [7:0] IX_RLH  = 8'hCB;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int B_M0   = 7;
   localparam int B_M1   = 6;
   localparam int B_MP   = 5;
   localparam int B_REN  = 4;
   localparam int B_TB8  = 3;
   localparam int B_RB8  = 2;
   localparam int B_TF   = 1;
   localparam int B_RF   = 0;
   localparam int B_DBL  = 7;
   localparam int B_T2RX = 5;
   localparam int B_T2TX = 4;
   localparam int B_DEN  = 7;
   localparam int B_XEN  = 0;
   localparam int B_OVR  = 1;
   localparam int DIV_LSB = 0;
   localparam int EXT_LSB = 3;
   localparam int FR_SH   = 6;
   // ----------------------------------------
   // Reset values and counts
   // ----------------------------------------
   localparam logic [7:0]  RST8     = 8'h00;
   localparam logic [15:0] RST16    = 16'h0000;
   localparam logic [3:0]  M0_LAST  = 4'hB;
   localparam logic [3:0]  M0_HALF  = 4'h6;
   localparam logic [3:0]  OVS_LAST = 4'hF;
   localparam logic [3:0]  OVS_MID  = 4'h7;
   localparam logic [3:0]  LEN9     = 4'hB;
   localparam logic [3:0]  LEN8     = 4'hA;
   localparam logic [3:0]  LEN0     = 4'h8;
   localparam logic [3:0]  DAT9     = 4'h9;
   localparam logic [3:0]  DAT8     = 4'h8;
   localparam logic [16:0] FR_BASE  = 17'h00040;
   localparam logic [15:0] T2_TOP   = 16'hFFFF;
   typedef enum logic [1:0] {
      SH_IDLE = 2'b00, SH_WAIT = 2'b01, SH_SEND = 2'b10, SH_SHIN = 2'b11
   } shift_st_e;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11
   } rx_st_e;
endpackage
`default_nettype wire

/* testbench/nine_bit_uart_asserts.sv */
`default_nettype none
module nine_bit_uart_chk (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [11:0] adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   input  wire logic [31:0] dat_o,
   input  wire logic        ack_o,
   input  wire logic        timer1_ovf_i,
   input  wire logic        rxd_i,
   input  wire logic        rxd_o,
   input  wire logic        rxd_oe_o,
   input  wire logic        txd_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Mode shadow, one cycle late by design
   // ----------------------------------------
   logic [1:0] mode_r;
   logic [1:0] mode_nxt;
   always_comb begin
      mode_nxt = mode_r;
      if (cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i == 12'h260) begin
         mode_nxt = dat_i[7:6];
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_r <= 2'b00;
      end else begin
         mode_r <= mode_nxt;
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   AST_ACK_NEXT: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o)
      else $error("ack missing after request");
   AST_ACK_ONE: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_CAUSE: assert property (!(cyc_i && stb_i) |=> !ack_o)
      else $error("ack without request");
   AST_DAT_QUIET: assert property (!ack_o |-> dat_o == 32'h0000_0000)
      else $error("read data outside ack");
   AST_DAT_NARROW: assert property (ack_o |-> dat_o[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   AST_RST_OUT: assert property ($fell(rst_i) |-> txd_o && rxd_o && !rxd_oe_o)
      else $error("pins not idle after reset");
   AST_TXD_LOW: assert property ($fell(txd_o) |=> !txd_o [*5])
      else $error("txd low run too short");
   AST_OE_MODE0: assert property (rxd_oe_o |-> mode_r == 2'b00)
      else $error("rxd driven outside shift mode");
   AST_IDLE_DRV: assert property (!rxd_oe_o |-> rxd_o)
      else $error("rxd data not parked high");
endmodule
bind nine_bit_uart nine_bit_uart_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
   .ack_o(ack_o), .timer1_ovf_i(timer1_ovf_i), .rxd_i(rxd_i), .rxd_o(rxd_o),
   .rxd_oe_o(rxd_oe_o), .txd_o(txd_o));
`default_nettype wire

/* testbench/remote_node.sv */
`default_nettype none
module remote_node (
   input  wire logic clk_i,
   input  wire logic txd_i,
   output var  logic rxd_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Far node: idle mark, whole frames or a short glitch
   // ----------------------------------------
   initial rxd_o = 1'b1;
   task automatic send(input logic [7:0] d, input logic nb, input int per);
      logic [10:0] f;
      f = {1'b1, nb, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rxd_o <= f[i];
         repeat (per) @(posedge clk_i);
      end
   endtask
   // Short low pulse, too brief to be a start bit
   task automatic glitch(input int len);
      rxd_o <= 1'b0;
      repeat (len) @(posedge clk_i);
      rxd_o <= 1'b1;
   endtask
   // Samples mid-bit, so a wrong bit period shows as wrong data
   task automatic recv(output logic [7:0] d, output logic nb, output logic sb, input int per);
      while (txd_i !== 1'b0) @(posedge clk_i);
      repeat (per / 2) @(posedge clk_i);
      for (int i = 0; i < 9; i++) begin
         repeat (per) @(posedge clk_i);
         if (i < 8) d[i] = txd_i;
         else nb = txd_i;
      end
      repeat (per) @(posedge clk_i);
      sb = txd_i;
      repeat (per / 2) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

/* testbench/test_nine_bit_uart.sv */
`default_nettype none
module test_nine_bit_uart;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i = 1'b0;
   logic [11:0] adr_i = 12'h000;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic        ack_o, rxd_o, rxd_oe_o, txd_o, node_rxd, rxd_w;
   logic        t1_on = 1'b0;
   logic        t1_ovf = 1'b0;
   int          err_count = 0;
   int          n_tests = 0;
   int          cycles = 0;
   assign rxd_w = rxd_oe_o ? rxd_o : node_rxd;
   nine_bit_uart dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .timer1_ovf_i(t1_ovf), .rxd_i(rxd_w), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o));
   remote_node node_u (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(node_rxd));
   initial begin
      forever #2 clk_i = ~clk_i;
   end
   // ----------------------------------------
   // Timer 1 stand-in and hang guard
   // ----------------------------------------
   always @(posedge clk_i) begin
      t1_ovf <= t1_on;
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         err_count++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      if (err_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Entered just after an edge; the wait is cut only by the hang guard
   task automatic wb(input logic w, input logic [7:0] ix, input logic [7:0] wd,
                     output logic [7:0] rd);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {2'b00, ix, 2'b00};
      sel_i <= 4'hF;
      dat_i <= {24'h0, wd};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] ix, input logic [7:0] wd);
      logic [7:0] x;
      wb(1'b1, ix, wd, x);
   endtask
   task automatic rd_chk(input logic [7:0] ix, input logic [7:0] exp);
      logic [7:0] x;
      wb(1'b0, ix, 8'h00, x);
      check({24'h0, x}, {24'h0, exp});
   endtask
   task automatic tx_chk(input logic [7:0] d, input logic nb, input int per);
      logic [7:0] rd;
      logic       rn, rs;
      wr(u9_pkg::IX_BUF, d);
      node_u.recv(rd, rn, rs, per);
      check({23'h0, rn, rd}, {23'h0, nb, d});
      check({31'h0, rs}, 32'h1);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      rd_chk(u9_pkg::IX_SCTL, 8'h00);
      wr(u9_pkg::IX_BINT, 8'hFF);
      rd_chk(u9_pkg::IX_BINT, 8'h1F);
      wr(u9_pkg::IX_BFR, 8'h7F);
      rd_chk(u9_pkg::IX_BFR, 8'h3F);
      wr(8'h90, 8'hFF);
      rd_chk(8'h90, 8'h00);
      wr(u9_pkg::IX_BINT, 8'h00);
      wr(u9_pkg::IX_BFR, 8'h00);
   endtask
   task automatic t_tx_fixed();
      for (int k = 0; k < 2; k++) begin
         wr(u9_pkg::IX_PWR, 8'(k << 7));
         wr(u9_pkg::IX_SCTL, 8'(8'h80 | (k << 3)));
         tx_chk(8'hA5, k[0], 32 >> k);
         rd_chk(u9_pkg::IX_SCTL, 8'(8'h82 | (k << 3)));
      end
   endtask
   task automatic t_rx();
      wr(u9_pkg::IX_PWR, 8'h80);
      wr(u9_pkg::IX_SCTL, 8'h90);
      node_u.send(8'h3C, 1'b1, 16);
      rd_chk(u9_pkg::IX_SCTL, 8'h95);
      rd_chk(u9_pkg::IX_BUF, 8'h3C);
      node_u.send(8'hC3, 1'b0, 16);
      rd_chk(u9_pkg::IX_SCTL, 8'h95);
      rd_chk(u9_pkg::IX_BUF, 8'h3C);
      wr(u9_pkg::IX_SCTL, 8'hB0);
      node_u.glitch(4);
      repeat (200) @(posedge clk_i);
      rd_chk(u9_pkg::IX_SCTL, 8'hB0);
      node_u.send(8'h55, 1'b0, 16);
      rd_chk(u9_pkg::IX_SCTL, 8'hB0);
      node_u.send(8'h66, 1'b1, 16);
      rd_chk(u9_pkg::IX_SCTL, 8'hB5);
      rd_chk(u9_pkg::IX_BUF, 8'h66);
      wr(u9_pkg::IX_UEXT, 8'h01);
      node_u.send(8'h77, 1'b1, 16);
      rd_chk(u9_pkg::IX_UEXT, 8'h03);
      rd_chk(u9_pkg::IX_BUF, 8'h77);
      rd_chk(u9_pkg::IX_UEXT, 8'h01);
      wr(u9_pkg::IX_UEXT, 8'h00);
   endtask
   // Rows: Timer 1 doubled and plain, Timer 2, divider overriding both, extended divider
   task automatic t_tx_var();
      logic [7:0] pw [5] = '{8'h80, 8'h00, 8'h00, 8'h80, 8'h00};
      logic [7:0] t2 [5] = '{8'h00, 8'h00, 8'h10, 8'h10, 8'h00};
      logic [7:0] bf [5] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h80};
      logic [7:0] bi [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08};
      logic       t1 [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      int         per [5] = '{16, 32, 32, 16, 32};
      wr(u9_pkg::IX_RLL, 8'hFF);
      wr(u9_pkg::IX_RLH, 8'hFF);
      for (int k = 0; k < 5; k++) begin
         t1_on <= t1[k];
         wr(u9_pkg::IX_PWR, pw[k]);
         wr(u9_pkg::IX_T2C, t2[k]);
         wr(u9_pkg::IX_BFR, bf[k]);
         wr(u9_pkg::IX_BINT, bi[k]);
         wr(u9_pkg::IX_SCTL, 8'hC8);
         tx_chk(8'h3B ^ 8'(k), 1'b1, per[k]);
         rd_chk(u9_pkg::IX_SCTL, 8'hCA);
      end
      t1_on <= 1'b0;
      wr(u9_pkg::IX_T2C, 8'h20);
      wr(u9_pkg::IX_BFR, 8'h00);
      wr(u9_pkg::IX_BINT, 8'h00);
      wr(u9_pkg::IX_SCTL, 8'hD0);
      node_u.send(8'h5A, 1'b1, 32);
      rd_chk(u9_pkg::IX_BUF, 8'h5A);
   endtask
   task automatic t_shift();
      int t0;
      t0 = 0;
      wr(u9_pkg::IX_SCTL, 8'h00);
      wr(u9_pkg::IX_BUF, 8'h96);
      for (int i = 0; i < 8; i++) begin
         while (txd_o !== 1'b0) @(posedge clk_i);
         if (i > 0) check(cycles - t0, 12);
         t0 = cycles;
         while (txd_o !== 1'b1) @(posedge clk_i);
         check({rxd_oe_o, rxd_o}, {1'b1, 1'(8'h96 >> i)});
      end
   endtask
   // Shift-mode receive starts at once; idle line shifts in all ones
   task automatic t_shift_rx();
      repeat (12) @(posedge clk_i);
      wr(u9_pkg::IX_SCTL, 8'h10);
      repeat (120) @(posedge clk_i);
      rd_chk(u9_pkg::IX_SCTL, 8'h11);
      rd_chk(u9_pkg::IX_BUF, 8'hFF);
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      t_tx_fixed();
      t_rx();
      t_tx_var();
      t_shift();
      t_shift_rx();
      wrap_up();
   end
endmodule
`default_nettype wire
